// ==== hw/tsf_pkg.sv ====
// What this block does
// - Addressing an absent drive sets bit 18; it interrupts when enabled.
// - Missing-drive flag clears only by reset or writing one, not by commands.
// - Bit 16 is the OR of drive attention bits; interrupts when enabled.
// - Attention summary ignores writes; drops only when every drive is clear.
// - Bit 13 sets when any transfer ends, normal or aborted; interrupts.
// - Bit 12 sets when a transfer aborts; interrupts when enabled.
// - Bits 13..0 clear by reset, valid transfer command, or writing one.
// - Write-check mismatch sets bit 10 or 9 and aborts the transfer.
// - Missed header, sector or buffer drain sets bit 8; interrupts.
// - Selected drive fault (drive status bit 14) sets bit 7, aborts.
// - Internal buffer parity error sets bit 6 and aborts the transfer.
// - Map read parity error during transfer sets bit 5 and aborts.
// - Bus error confirmation on issued command sets bit 3 and aborts.
// - Read data tagged substitute sets bit 2 and aborts the transfer.
// - No bus ACK or error within 102.4 us of arbitration sets bit 1, aborts.
// - Read data not back within 102.4 us after command sets bit 0, aborts.
// - Read-only bit 31 sets on accepted transfer, clears when it ends.
// - Starting a transfer while one is busy sets misuse bit 19.
package tsf_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam int BIT_BUSY = 31;
    localparam int BIT_MISUSE = 19;
    localparam int BIT_MISSING = 18;
    localparam int BIT_ATTENTION_SUMMARY = 16;
    localparam int BIT_DONE = 13;
    localparam int BIT_ABORT = 12;
    localparam int BIT_WCU = 10;
    localparam int BIT_WCL = 9;
    localparam int BIT_MISSED = 8;
    localparam int BIT_FAULT = 7;
    localparam int BIT_BUFPAR = 6;
    localparam int BIT_MAPPAR = 5;
    localparam int BIT_ECONF = 3;
    localparam int BIT_SUBST = 2;
    localparam int BIT_SEQTO = 1;
    localparam int BIT_RDTO = 0;
    localparam int BIT_IE = 0;
    localparam int DRIVE_FAULT_BIT = 14;
    // Write-one-to-clear transfer flags, bits 13..0
    localparam logic [31:0] XFER_MASK = 32'h0000_37ef;
    localparam logic [31:0] W1C_MASK = 32'h000c_37ef;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int CLK_MHZ_X10 = 400;
    localparam int TIMEOUT_NS_X10 = 1024000;
    // Longest time rounds down: 102.4 us at 40 MHz
    localparam int TIMEOUT_CYCLES = (TIMEOUT_NS_X10 / 10) * CLK_MHZ_X10
        / 10000;
endpackage

// ==== hw/tsf_timer.sv ====
`timescale 1ns/1ps
module tsf_timer
    import tsf_pkg::*;
#(
    parameter int LIMIT = TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    output logic expired
);
    logic [15:0] count;

    // Counts while run is high; one pulse when the limit is reached
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (!run) begin
                count <= 16'h0000;
            end else if (count == 16'(LIMIT - 1)) begin
                expired <= 1'b1;
                count <= 16'h0000;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule

// ==== hw/tsf_sync.sv ====
`timescale 1ns/1ps
module tsf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== hw/tsf_top.sv ====
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module tsf_top
    import tsf_pkg::*;
#(
    parameter int DRIVES = 8,
    parameter int TIMEOUT = TIMEOUT_CYCLES
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transfer engine events, same clock, one-cycle pulses
    input wire logic xfer_start,
    input wire logic xfer_finish,
    input wire logic absent_drive,
    input wire logic wc_upper_mismatch,
    input wire logic wc_lower_mismatch,
    input wire logic missed_transfer,
    input wire logic buffer_parity_err,
    input wire logic map_parity_err,
    input wire logic bus_error_confirm,
    input wire logic read_substitute_tag,
    // Bus sequencing, same clock, levels and pulses
    input wire logic arbitration_start,
    input wire logic bus_ack,
    input wire logic read_seq_done,
    input wire logic read_data_back,
    // Drives, asynchronous pins
    input wire logic [DRIVES-1:0] drive_attention,
    input wire logic [15:0] drive_status_register,
    // Status to the engine
    output logic xfer_busy,
    output logic xfer_abort,
    output logic irq
);
    logic [DRIVES-1:0] attention_summary_sync;
    logic [15:0] dstat_sync;
    logic missing_drive_flag;
    logic attention_summary;
    logic transfer_done_flag;
    logic transfer_abort_flag;
    logic write_check_upper_mismatch;
    logic write_check_lower_mismatch;
    logic missed_transfer_flag;
    logic drive_fault_flag;
    logic buffer_parity_fault;
    logic map_parity_fault;
    logic bus_error_confirm_flag;
    logic read_substitute_tag_flag;
    logic interface_sequence_timeout;
    logic read_return_timeout;
    logic program_misuse_flag;
    logic interrupt_enable_bit;
    logic seq_wait;
    logic rd_wait;
    logic seq_expired;
    logic rd_expired;
    logic fault_seen;
    logic abort_cause;
    logic accept;
    logic misuse;
    logic [31:0] status_word;
    logic [31:0] clr;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    tsf_sync #(
        .WIDTH(DRIVES + 16)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({drive_attention, drive_status_register}),
        .q({attention_summary_sync, dstat_sync})
    );

    // Waits: arbitration until ACK or error, read sequence until data back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_wait <= 1'b0;
            rd_wait <= 1'b0;
        end else if (ce) begin
            if (bus_ack || bus_error_confirm || xfer_abort || !xfer_busy) begin
                seq_wait <= 1'b0;
            end else if (arbitration_start) begin
                seq_wait <= 1'b1;
            end
            if (read_data_back || xfer_abort || !xfer_busy) begin
                rd_wait <= 1'b0;
            end else if (read_seq_done) begin
                rd_wait <= 1'b1;
            end
        end
    end

    tsf_timer #(
        .LIMIT(TIMEOUT)
    ) u_seq_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(seq_wait),
        .expired(seq_expired)
    );

    tsf_timer #(
        .LIMIT(TIMEOUT)
    ) u_rd_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(rd_wait),
        .expired(rd_expired)
    );

    assign fault_seen = xfer_busy && dstat_sync[DRIVE_FAULT_BIT];
    assign accept = xfer_start && !xfer_busy;
    assign misuse = xfer_start && xfer_busy;

    // Any error that ends the transfer early
    assign abort_cause = xfer_busy && (wc_upper_mismatch
        || wc_lower_mismatch || fault_seen || buffer_parity_err
        || map_parity_err || bus_error_confirm || read_substitute_tag
        || seq_expired || rd_expired);
    assign xfer_abort = abort_cause;

    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = ce && aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == ADDR_STATUS || aw_addr == ADDR_CONTROL) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane masked write-one-to-clear, zeros leave bits alone
    always_comb begin
        clr = 32'h0000_0000;
        if (do_write && aw_addr == ADDR_STATUS) begin
            clr = w_data & W1C_MASK & {{8{w_strb[3]}}, {8{w_strb[2]}},
                {8{w_strb[1]}}, {8{w_strb[0]}}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_enable_bit <= 1'b0;
        end else if (ce && do_write && aw_addr == ADDR_CONTROL
            && w_strb[0]) begin
            interrupt_enable_bit <= w_data[BIT_IE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_busy <= 1'b0;
        end else if (ce) begin
            if (accept) begin
                xfer_busy <= 1'b1;
            end else if (xfer_finish || abort_cause) begin
                xfer_busy <= 1'b0;
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            missing_drive_flag <= 1'b0;
            program_misuse_flag <= 1'b0;
        end else if (ce) begin
            if (absent_drive) begin
                missing_drive_flag <= 1'b1;
            end else if (clr[BIT_MISSING]) begin
                missing_drive_flag <= 1'b0;
            end
            if (misuse) begin
                program_misuse_flag <= 1'b1;
            end else if (clr[BIT_MISUSE]) begin
                program_misuse_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            attention_summary <= 1'b0;
        end else if (ce) begin
            attention_summary <= |attention_summary_sync;
        end
    end

    // Transfer flags; set beats clear, command accept clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transfer_done_flag <= 1'b0;
            transfer_abort_flag <= 1'b0;
            write_check_upper_mismatch <= 1'b0;
            write_check_lower_mismatch <= 1'b0;
            missed_transfer_flag <= 1'b0;
            drive_fault_flag <= 1'b0;
            buffer_parity_fault <= 1'b0;
            map_parity_fault <= 1'b0;
            bus_error_confirm_flag <= 1'b0;
            read_substitute_tag_flag <= 1'b0;
            interface_sequence_timeout <= 1'b0;
            read_return_timeout <= 1'b0;
        end else if (ce) begin
            transfer_done_flag <= (xfer_busy && (xfer_finish || abort_cause))
                || (transfer_done_flag && !accept && !clr[BIT_DONE]);
            transfer_abort_flag <= abort_cause
                || (transfer_abort_flag && !accept && !clr[BIT_ABORT]);
            write_check_upper_mismatch <= (xfer_busy && wc_upper_mismatch)
                || (write_check_upper_mismatch && !accept
                && !clr[BIT_WCU]);
            write_check_lower_mismatch <= (xfer_busy && wc_lower_mismatch)
                || (write_check_lower_mismatch && !accept
                && !clr[BIT_WCL]);
            missed_transfer_flag <= (xfer_busy && missed_transfer)
                || (missed_transfer_flag && !accept
                && !clr[BIT_MISSED]);
            drive_fault_flag <= fault_seen
                || (drive_fault_flag && !accept && !clr[BIT_FAULT]);
            buffer_parity_fault <= (xfer_busy && buffer_parity_err)
                || (buffer_parity_fault && !accept
                && !clr[BIT_BUFPAR]);
            map_parity_fault <= (xfer_busy && map_parity_err)
                || (map_parity_fault && !accept && !clr[BIT_MAPPAR]);
            bus_error_confirm_flag <= (xfer_busy && bus_error_confirm)
                || (bus_error_confirm_flag && !accept
                && !clr[BIT_ECONF]);
            read_substitute_tag_flag <= (xfer_busy && read_substitute_tag)
                || (read_substitute_tag_flag && !accept
                && !clr[BIT_SUBST]);
            interface_sequence_timeout <= (xfer_busy && seq_expired)
                || (interface_sequence_timeout && !accept
                && !clr[BIT_SEQTO]);
            read_return_timeout <= (xfer_busy && rd_expired)
                || (read_return_timeout && !accept
                && !clr[BIT_RDTO]);
        end
    end

    // Unlisted positions stay zero
    always_comb begin
        status_word = STATUS_RESET;
        status_word[BIT_BUSY] = xfer_busy;
        status_word[BIT_MISUSE] = program_misuse_flag;
        status_word[BIT_MISSING] = missing_drive_flag;
        status_word[BIT_ATTENTION_SUMMARY] = attention_summary;
        status_word[BIT_DONE] = transfer_done_flag;
        status_word[BIT_ABORT] = transfer_abort_flag;
        status_word[BIT_WCU] = write_check_upper_mismatch;
        status_word[BIT_WCL] = write_check_lower_mismatch;
        status_word[BIT_MISSED] = missed_transfer_flag;
        status_word[BIT_FAULT] = drive_fault_flag;
        status_word[BIT_BUFPAR] = buffer_parity_fault;
        status_word[BIT_MAPPAR] = map_parity_fault;
        status_word[BIT_ECONF] = bus_error_confirm_flag;
        status_word[BIT_SUBST] = read_substitute_tag_flag;
        status_word[BIT_SEQTO] = interface_sequence_timeout;
        status_word[BIT_RDTO] = read_return_timeout;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= interrupt_enable_bit && (missing_drive_flag
                || attention_summary || transfer_done_flag
                || transfer_abort_flag || missed_transfer_flag);
        end
    end

    // AXI4-Lite read, one outstanding
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                if (s_axi_araddr == ADDR_STATUS) begin
                    s_axi_rdata <= status_word;
                end else if (s_axi_araddr == ADDR_CONTROL) begin
                    s_axi_rdata <= {31'h0000_0000, interrupt_enable_bit};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/tsf_drive_model.sv ====
`timescale 1ns/1ps
module tsf_drive_model #(
    parameter int DRIVES = 4
) (
    // Clock
    input wire logic aclk,
    // Requests from the bench
    input wire logic [DRIVES-1:0] attention_summary_req,
    input wire logic fault_req,
    // Drive pins
    output logic [DRIVES-1:0] drive_attention,
    output logic [15:0] drive_status_register
);
    logic [DRIVES-1:0] attention_summary_q = '0;
    logic fault_q = 1'b0;
    logic [13:0] noise = 14'h0;

    // Unused status bits 13..0 keep moving so that nothing relies on them; bit 15 stays zero
    always_ff @(posedge aclk) begin
        attention_summary_q <= attention_summary_req;
        fault_q <= fault_req;
        noise <= noise + 14'h1;
    end

    assign drive_attention = attention_summary_q;
    assign drive_status_register = {1'b0, fault_q, noise};
endmodule

// ==== bench/tsf_top_properties.sv ====
`timescale 1ns/1ps
module tsf_top_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register bus
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transfer events
    input wire logic xfer_start,
    input wire logic xfer_finish,
    input wire logic wc_upper_mismatch,
    input wire logic wc_lower_mismatch,
    input wire logic buffer_parity_err,
    input wire logic map_parity_err,
    input wire logic bus_error_confirm,
    input wire logic read_substitute_tag,
    // Status
    input wire logic xfer_busy,
    input wire logic xfer_abort
);
    logic any_err;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    assign any_err = wc_upper_mismatch | wc_lower_mismatch |
        buffer_parity_err | map_parity_err | bus_error_confirm |
        read_substitute_tag;

    busy_set_a: assert property (
        ce && xfer_start && !xfer_busy |=> xfer_busy)
        else $error("busy not raised by accepted start");
    busy_end_a: assert property (
        ce && xfer_busy && xfer_finish |=> !xfer_busy)
        else $error("busy not dropped at finish");
    abort_end_a: assert property (
        ce && xfer_abort |=> !xfer_busy)
        else $error("busy not dropped at abort");
    error_abort_a: assert property (
        ce && xfer_busy && any_err |-> xfer_abort)
        else $error("error while busy did not abort");
    busy_rise_a: assert property (
        !xfer_busy && !xfer_start |=> !xfer_busy)
        else $error("busy raised without a start");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    reserved_zero_a: assert property (
        s_axi_rvalid |-> (s_axi_rdata & 32'h7ff2_c810) == 32'h0)
        else $error("reserved bits read nonzero");
endmodule

bind tsf_top tsf_top_properties i_props (.*);

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import tsf_pkg::*;
    typedef enum int {EV_START, EV_FINISH, EV_ABSENT, EV_WC_HI, EV_WC_LO,
        EV_MISSED, EV_BUFPAR, EV_MAPPAR, EV_ECONF, EV_SUBST, EV_ARB,
        EV_ACK, EV_RSEQ, EV_RBACK} tsf_ev_t;
    localparam int TMO = 16;
    localparam logic [31:0] BUSY = 32'h1 << BIT_BUSY;
    localparam logic [31:0] DONE = 32'h1 << BIT_DONE;
    localparam logic [31:0] DA = DONE | (32'h1 << BIT_ABORT);
    localparam logic [31:0] MISS = 32'h1 << BIT_MISSING;
    localparam logic [31:0] ATTENTION_SUMMARY = 32'h1 << BIT_ATTENTION_SUMMARY;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [13:0] ev = 14'h0;
    logic [3:0] attention_summary_req = 4'h0;
    logic fault_req = 1'b0;
    logic [3:0] drive_attention;
    logic [15:0] drive_status_register;
    logic xfer_busy;
    logic xfer_abort;
    logic irq;
    int bad_count = 0;
    int cmp_count = 0;

    tsf_drive_model #(.DRIVES(4)) i_drives (
        .aclk(aclk),
        .attention_summary_req(attention_summary_req),
        .fault_req(fault_req),
        .drive_attention(drive_attention),
        .drive_status_register(drive_status_register)
    );

    tsf_top #(.DRIVES(4), .TIMEOUT(TMO)) i_dut (
        .*,
        .xfer_start(ev[0]),
        .xfer_finish(ev[1]),
        .absent_drive(ev[2]),
        .wc_upper_mismatch(ev[3]),
        .wc_lower_mismatch(ev[4]),
        .missed_transfer(ev[5]),
        .buffer_parity_err(ev[6]),
        .map_parity_err(ev[7]),
        .bus_error_confirm(ev[8]),
        .read_substitute_tag(ev[9]),
        .arbitration_start(ev[10]),
        .bus_ack(ev[11]),
        .read_seq_done(ev[12]),
        .read_data_back(ev[13])
    );

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic stat(input logic [31:0] e, input string nm);
        logic [31:0] v;
        rd(ADDR_STATUS, v, RESP_OKAY);
        check(nm, v, e);
    endtask

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        stat(STATUS_RESET, "status after reset");
        rd(ADDR_CONTROL, v, RESP_OKAY);
        check("control after reset", v, 32'h0);
        rd(8'h08, v, RESP_SLVERR);
        check("unmapped read", v, 32'h0);
        wr(8'h08, 32'hffff_ffff, RESP_SLVERR);
        stat(STATUS_RESET, "unmapped write");
        $display("test reset finished");
    endtask

    task automatic t_errors();
        int e [7] = '{EV_WC_HI, EV_WC_LO, EV_MISSED, EV_BUFPAR, EV_MAPPAR,
            EV_ECONF, EV_SUBST};
        int f [7] = '{10, 9, 8, 6, 5, 3, 2};
        for (int i = 0; i < 7; i++) begin
            pulse(EV_START);
            stat(BUSY, "start clears flags");
            pulse(e[i]);
            pulse(EV_FINISH);
            stat((32'h1 << f[i]) | (i == 2 ? DONE : DA),
                "error");
        end
        $display("test errors finished");
    endtask

    task automatic t_timeout();
        pulse(EV_START);
        pulse(EV_ARB);
        repeat (4) @(posedge aclk);
        pulse(EV_ACK);
        pulse(EV_RSEQ);
        repeat (4) @(posedge aclk);
        pulse(EV_RBACK);
        repeat (TMO + 4) @(posedge aclk);
        stat(BUSY, "answers in time");
        pulse(EV_ARB);
        repeat (TMO + 4) @(posedge aclk);
        stat((32'h1 << BIT_SEQTO) | DA, "sequence timeout");
        pulse(EV_START);
        pulse(EV_RSEQ);
        repeat (TMO + 4) @(posedge aclk);
        stat((32'h1 << BIT_RDTO) | DA, "read timeout");
        $display("test timeout finished");
    endtask

    task automatic t_missing();
        pulse(EV_ABSENT);
        stat(MISS | (32'h1 << BIT_RDTO) | DA, "absent drive");
        wr(ADDR_STATUS, W1C_MASK & ~MISS, RESP_OKAY);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("irq enabled", {31'h0, irq}, 32'h1);
        pulse(EV_START);
        pulse(EV_START);
        pulse(EV_FINISH);
        stat(MISS | DONE | (32'h1 << BIT_MISUSE), "command keeps");
        wr(ADDR_STATUS, 32'h0, RESP_OKAY);
        stat(MISS | DONE | (32'h1 << BIT_MISUSE), "zero write");
        wr(ADDR_STATUS, W1C_MASK, RESP_OKAY);
        stat(32'h0, "ones clear");
        repeat (2) @(posedge aclk);
        check("irq idle", {31'h0, irq}, 32'h0);
        wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
        $display("test missing finished");
    endtask

    task automatic t_drive();
        attention_summary_req <= 4'h8;
        repeat (6) @(posedge aclk);
        stat(ATTENTION_SUMMARY, "attention");
        wr(ADDR_STATUS, W1C_MASK | ATTENTION_SUMMARY, RESP_OKAY);
        stat(ATTENTION_SUMMARY, "attention kept");
        attention_summary_req <= 4'h0;
        repeat (6) @(posedge aclk);
        stat(32'h0, "attention gone");
        pulse(EV_START);
        fault_req <= 1'b1;
        repeat (6) @(posedge aclk);
        fault_req <= 1'b0;
        stat((32'h1 << BIT_FAULT) | DA, "drive fault");
        pulse(EV_ABSENT);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        stat(STATUS_RESET, "reset clears");
        $display("test drive finished");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_errors();
        t_timeout();
        t_missing();
        t_drive();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
